/* inc/hic_params.svh */
// constants of the host i/o channel controller
`ifndef HIC_PARAMS_SVH
`define HIC_PARAMS_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HIC_CLK_NS 50
`define HIC_STAGGER_NS 100
`define HIC_REMOVE_NS 100
`define HIC_TIMEOUT_NS 10000
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define HIC_OFS_OP 8'h00
`define HIC_OFS_OUT 8'h04
`define HIC_OFS_STAT 8'h08
`define HIC_OFS_IN 8'h0C
`define HIC_OFS_CLEAR 8'h10
// ----------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------
`define HIC_ST_BUSY 0
`define HIC_ST_DONE 1
`define HIC_ST_TIMEOUT 2
`define HIC_ST_ATTN 3
`define HIC_ST_CLEAR 4
// ----------------------------------------------------------------
// reset values and line indices
// ----------------------------------------------------------------
`define HIC_LINES_IDLE 8'hFF
`define HIC_ACK_LINE 5
`define HIC_OP_LAST 3'h5
`endif

/* inc/hic_pkg.sv */
// types of the host i/o channel controller
package hic_pkg;
  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_STROBE = 3'h2,
    ST_RELEASE = 3'h3,
    ST_HOLD = 3'h4
  } hic_state_e;
  // ----------------------------------------------------------------
  // operations; the code is the index of the control strobe line
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_ADDR = 3'h0,
    OP_STAT = 3'h1,
    OP_DREQ = 3'h2,
    OP_DOUT = 3'h3,
    OP_CMD = 3'h4,
    OP_ACK = 3'h5
  } hic_op_e;
  // ----------------------------------------------------------------
  // outbound bus lines, active low
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] strobe_n;
    logic [7:0] out_n;
  } hic_bus_s;
endpackage

/* rtl/hic_host.sv */
// host side i/o channel controller driving the byte-wide device bus
`timescale 1ns/10ps
`include "hic_params.svh"

module hic_host (
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  // software register port
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WR_DATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RD_DATA_OUT,
  // device bus, outbound
  // bus line groups
  output logic [7:0] HOST_OUT_LINES_N_OUT,
  output logic [7:0] CONTROL_STROBE_LINES_N_OUT,
  output logic SYSTEM_CLEAR_LINE_N_OUT,
  // device bus, inbound
  input wire logic [7:0] DEVICE_RETURN_LINES_N_IN,
  input wire logic HANDSHAKE_RETURN_N_IN,
  input wire logic ATTENTION_REQUEST_N_IN
);

  // ----------------------------------------------------------------
  // cycle counts
  // ----------------------------------------------------------------
  function automatic logic [7:0] ns_to_cyc(input int ns, input bit up);
    int c;
    c = up ? (ns + `HIC_CLK_NS - 1) / `HIC_CLK_NS : ns / `HIC_CLK_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[7:0];
  endfunction

  localparam logic [7:0] STAGGER_CYC = ns_to_cyc(`HIC_STAGGER_NS, 1'b1);
  localparam logic [7:0] REMOVE_CYC = ns_to_cyc(`HIC_REMOVE_NS, 1'b1);
  localparam logic [7:0] TIMEOUT_CYC = ns_to_cyc(`HIC_TIMEOUT_NS, 1'b0);

  hic_pkg::hic_state_e state;
  hic_pkg::hic_op_e op;
  hic_pkg::hic_bus_s bus;
  logic [7:0] cnt;
  logic [7:0] out_byte;
  logic [7:0] in_byte;
  logic [9:0] sync1;
  logic [9:0] sync2;
  logic done;
  logic timeout;
  logic clear_on;
  logic [7:0] return_byte_n;
  logic handshake_n;
  logic attention_n;
  logic launch;
  logic handshake_seen;
  logic strobe_to;
  logic release_end;
  logic hold_end;

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  // two flop sync
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      sync1 <= 10'h3FF;
      sync2 <= 10'h3FF;
    end else begin
      sync1 <= {ATTENTION_REQUEST_N_IN, HANDSHAKE_RETURN_N_IN,
                DEVICE_RETURN_LINES_N_IN};
      sync2 <= sync1;
    end
  end

  assign return_byte_n = sync2[7:0];
  assign handshake_n = sync2[8];
  assign attention_n = sync2[9];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  assign launch = WR_IN && (ADDR_IN == `HIC_OFS_OP) &&
                  (state == hic_pkg::ST_IDLE) &&
                  (WR_DATA_IN[2:0] <= `HIC_OP_LAST);
  assign handshake_seen = (state == hic_pkg::ST_STROBE) && !handshake_n;
  assign strobe_to = (state == hic_pkg::ST_STROBE) && handshake_n &&
                     (cnt == 8'h00);
  assign release_end = (state == hic_pkg::ST_RELEASE) &&
                       (handshake_n || (cnt == 8'h00));
  assign hold_end = (state == hic_pkg::ST_HOLD) && (cnt == 8'h00);

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      state <= hic_pkg::ST_IDLE;
      op <= hic_pkg::OP_ADDR;
      cnt <= 8'h00;
    end else begin
      case (state)
        hic_pkg::ST_IDLE: begin
          if (launch) begin
            op <= hic_pkg::hic_op_e'(WR_DATA_IN[2:0]);
            cnt <= STAGGER_CYC - 8'h01;
            state <= hic_pkg::ST_SETUP;
          end
        end
        hic_pkg::ST_SETUP: begin
          if (cnt == 8'h00) begin
            cnt <= TIMEOUT_CYC - 8'h01;
            state <= hic_pkg::ST_STROBE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        hic_pkg::ST_STROBE: begin
          if (handshake_seen || strobe_to) begin
            cnt <= TIMEOUT_CYC - 8'h01;
            state <= hic_pkg::ST_RELEASE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        hic_pkg::ST_RELEASE: begin
          if (release_end) begin
            cnt <= REMOVE_CYC - 8'h01;
            state <= hic_pkg::ST_HOLD;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        hic_pkg::ST_HOLD: begin
          if (hold_end) begin
            state <= hic_pkg::ST_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: begin
          state <= hic_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bus drivers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      bus.strobe_n <= `HIC_LINES_IDLE;
      bus.out_n <= `HIC_LINES_IDLE;
    end else begin
      if (launch) begin
        case (WR_DATA_IN[2:0])
          hic_pkg::OP_ADDR, hic_pkg::OP_DOUT, hic_pkg::OP_CMD: begin
            bus.out_n <= ~out_byte;
          end
          default: begin
            bus.out_n <= `HIC_LINES_IDLE;
          end
        endcase
      end else if (hold_end) begin
        bus.out_n <= `HIC_LINES_IDLE;
      end
      if ((state == hic_pkg::ST_SETUP) && (cnt == 8'h00)) begin
        bus.strobe_n <= ~(8'h01 << op);
      end else if (handshake_seen || strobe_to) begin
        bus.strobe_n <= `HIC_LINES_IDLE;
      end
    end
  end

  assign HOST_OUT_LINES_N_OUT = bus.out_n;
  assign CONTROL_STROBE_LINES_N_OUT = bus.strobe_n;

  // ----------------------------------------------------------------
  // software registers and flags
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      out_byte <= 8'h00;
      in_byte <= 8'h00;
      done <= 1'b0;
      timeout <= 1'b0;
      clear_on <= 1'b0;
      SYSTEM_CLEAR_LINE_N_OUT <= 1'b1;
    end else begin
      if (WR_IN && (ADDR_IN == `HIC_OFS_OUT)) begin
        out_byte <= WR_DATA_IN;
      end
      if (WR_IN && (ADDR_IN == `HIC_OFS_CLEAR)) begin
        clear_on <= WR_DATA_IN[0];
        SYSTEM_CLEAR_LINE_N_OUT <= ~WR_DATA_IN[0];
      end
      if (handshake_seen) begin
        in_byte <= ~return_byte_n;
      end
      if (launch) begin
        done <= 1'b0;
        timeout <= 1'b0;
      end else begin
        if (hold_end) begin
          done <= 1'b1;
        end
        if (strobe_to || ((state == hic_pkg::ST_RELEASE) && !handshake_n &&
            (cnt == 8'h00))) begin
          timeout <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      RD_DATA_OUT <= 8'h00;
    end else if (RD_IN) begin
      case (ADDR_IN)
        `HIC_OFS_OUT: RD_DATA_OUT <= out_byte;
        `HIC_OFS_IN: RD_DATA_OUT <= in_byte;
        `HIC_OFS_STAT: begin
          RD_DATA_OUT <= 8'h00;
          RD_DATA_OUT[`HIC_ST_BUSY] <= (state != hic_pkg::ST_IDLE);
          RD_DATA_OUT[`HIC_ST_DONE] <= done;
          RD_DATA_OUT[`HIC_ST_TIMEOUT] <= timeout;
          RD_DATA_OUT[`HIC_ST_ATTN] <= ~attention_n;
          RD_DATA_OUT[`HIC_ST_CLEAR] <= clear_on;
        end
        default: RD_DATA_OUT <= 8'h00;
      endcase
    end else begin
      RD_DATA_OUT <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  one_strobe_a: assert property ($onehot0(~bus.strobe_n))
    else $error("more than one control strobe asserted");

  stagger_out_a: assert property (
    ($fell(&bus.strobe_n)) |-> (bus.out_n == $past(bus.out_n, 2)))
    else $error("out byte changed within stagger before strobe");

  release_sync_a: assert property (
    handshake_seen |=> (&bus.strobe_n))
    else $error("strobe not released after sync");

  drop_wait_a: assert property (
    (state == hic_pkg::ST_RELEASE && !handshake_n && cnt != 8'h00)
    |=> (state == hic_pkg::ST_RELEASE))
    else $error("left release while sync still asserted");

  idle_high_a: assert property (
    (state == hic_pkg::ST_IDLE) |-> (&bus.strobe_n) && (&bus.out_n))
    else $error("bus lines asserted while idle");

  ack_line_a: assert property (
    (state == hic_pkg::ST_STROBE && op == hic_pkg::OP_ACK)
    |-> (bus.strobe_n == ~(8'h01 << `HIC_ACK_LINE)))
    else $error("acknowledge op drove wrong strobe");

  strobe_byte_a: assert property (
    (!(&bus.strobe_n)) |-> $stable(bus.out_n))
    else $error("out byte changed under an active strobe");

  strobe_bound_a: assert property (
    $fell(&bus.strobe_n) |-> ##[1:210] (&bus.strobe_n))
    else $error("strobe held beyond timeout");

  addr_done_c: cover property (hold_end && op == hic_pkg::OP_ADDR);
  read_sync_c: cover property (handshake_seen && op == hic_pkg::OP_DREQ);
  timeout_c: cover property (strobe_to);
  ack_done_c: cover property (hold_end && op == hic_pkg::OP_ACK);

endmodule // hic_host

/* verif/hic_dev_model.sv */
// device side bus model answering the host channel controller
`timescale 1ns/10ps

module hic_dev_model #(
  parameter logic [7:0] DEV_NUM = 8'h3A
) (
  // clock and bus from host
  input wire logic clk_in,
  input wire logic clear_n_in,
  input wire logic [7:0] out_n_in,
  input wire logic [7:0] strobe_n_in,
  // bench controls
  input wire logic slow_in,
  input wire logic irq_in,
  input wire logic [3:0] cond_in,
  // bus to host
  output logic [7:0] ret_n_out,
  output logic sync_n_out,
  output logic attn_n_out
);
  logic sel = 1'b0;
  logic ctl = 1'b0;
  logic ind = 1'b0;
  logic gate = 1'b0;
  logic [7:0] data = 8'h00;
  int cnt = 0;
  logic [7:0] act;
  logic [7:0] o;
  logic take;
  assign act = ~strobe_n_in;
  assign o = ~out_n_in;
  assign take = act[0] | (sel & |act[4:1]) | (act[5] & irq_in & gate);
  assign sync_n_out = !(take && cnt >= (slow_in ? 12 : 4));
  assign attn_n_out = !(irq_in && gate);
  assign ret_n_out = !take ? 8'hFF : act[1] ? ~{cond_in, 2'b00, ind, ctl} :
    act[2] ? ~data : act[5] ? ~DEV_NUM : 8'hFF;
  always @(posedge clk_in) begin
    cnt <= take ? cnt + 1 : 0;
    if (!clear_n_in) begin
      sel <= 1'b0;
      ctl <= 1'b0;
      ind <= 1'b0;
      gate <= 1'b0;
      data <= 8'h00;
    end else if (take && cnt == 0) begin
      if (act[0]) sel <= (o == DEV_NUM);
      if (act[3]) data <= o;
      if (act[4]) begin
        ctl <= o[1] ? 1'b0 : (o[0] ? 1'b1 : ctl);
        gate <= o[3] ? 1'b0 : (o[2] ? 1'b1 : gate);
        ind <= o[7] ? 1'b0 : (o[6] ? 1'b1 : ind);
      end
    end
  end
endmodule // hic_dev_model

/* verif/hic_host_tb.sv */
// testbench of the host i/o channel controller
`timescale 1ns/10ps
`include "hic_params.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %0t got %h want %h", $time, g, e); end end

module hic_host_tb;
  localparam logic [7:0] DEV = 8'h3A;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic slow = 1'b0, irq = 1'b0, clr_n, sync_n, attn_n;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdat, out_n, stb_n, ret_n;
  logic [3:0] cond = 4'h0;
  logic m_sel = 1'b0, m_ctl = 1'b0, m_ind = 1'b0, m_gate = 1'b0;
  logic m_clr = 1'b0;
  logic [7:0] m_data = 8'h00, m_stat = 8'h00, v, b;
  logic [2:0] op;
  int n_mismatch = 0, total_checks = 0, cyc = 0, i, r;
  integer seed = 32'h635e;
  // ----------------------------------------------------------------
  // design and device model
  // ----------------------------------------------------------------
  hic_host i_hic_host (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr),
    .WR_DATA_IN(wdat), .WR_IN(wr), .RD_IN(rd), .RD_DATA_OUT(rdat),
    .HOST_OUT_LINES_N_OUT(out_n), .CONTROL_STROBE_LINES_N_OUT(stb_n),
    .SYSTEM_CLEAR_LINE_N_OUT(clr_n), .DEVICE_RETURN_LINES_N_IN(ret_n),
    .HANDSHAKE_RETURN_N_IN(sync_n), .ATTENTION_REQUEST_N_IN(attn_n));
  hic_dev_model #(.DEV_NUM(DEV)) i_hic_dev_model (.clk_in(clk),
    .clear_n_in(clr_n), .out_n_in(out_n), .strobe_n_in(stb_n),
    .slow_in(slow), .irq_in(irq), .cond_in(cond), .ret_n_out(ret_n),
    .sync_n_out(sync_n), .attn_n_out(attn_n));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      close_out();
    end
  end
  always @(negedge clk) begin
    if (rst_n)
      `CHK(stb_n[7:6] == 2'b11 && $countones(~stb_n) <= 1, 1'b1)
  end
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdat;
  endtask
  task automatic run_op(input logic [2:0] o, input logic [7:0] x);
    logic to;
    logic [7:0] ein;
    int k;
    wr_reg(`HIC_OFS_OUT, x);
    wr_reg(`HIC_OFS_OP, {5'h00, o});
    to = 1'b0;
    ein = 8'h00;
    if (o == 3'h0) m_sel = (x == DEV);
    else if (o == 3'h5) begin
      if (irq && m_gate) ein = DEV;
      else to = 1'b1;
    end else if (!m_sel || m_clr) to = 1'b1;
    else if (o == 3'h1) ein = {cond, 2'b00, m_ind, m_ctl};
    else if (o == 3'h2) ein = m_data;
    else if (o == 3'h3) m_data = x;
    else begin
      m_ctl = x[1] ? 1'b0 : (x[0] ? 1'b1 : m_ctl);
      m_gate = x[3] ? 1'b0 : (x[2] ? 1'b1 : m_gate);
      m_ind = x[7] ? 1'b0 : (x[6] ? 1'b1 : m_ind);
    end
    k = 0;
    v = 8'h01;
    while (v[`HIC_ST_BUSY] !== 1'b0 && k < 300) begin
      rd_reg(`HIC_OFS_STAT, v);
      k++;
    end
    m_stat = {3'b000, m_clr, irq & m_gate, to, 2'b10};
    `CHK(v, m_stat)
    rd_reg(`HIC_OFS_IN, v);
    if (!to) `CHK(v, ein)
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK({out_n, stb_n, clr_n}, 17'h1FFFF)
    rd_reg(8'h14, v);
    `CHK(v, 8'h00)
    run_op(3'h0, DEV);
    run_op(3'h3, 8'hA5);
    rd_reg(`HIC_OFS_OUT, v);
    `CHK(v, 8'hA5)
    run_op(3'h2, 8'h00);
    run_op(3'h4, 8'h41);
    run_op(3'h1, 8'h00);
    run_op(3'h4, 8'h82);
    run_op(3'h1, 8'h00);
    run_op(3'h4, 8'h05);
    @(posedge clk);
    irq <= 1'b1;
    run_op(3'h5, 8'h00);
    wr_reg(`HIC_OFS_OP, 8'h06);
    rd_reg(`HIC_OFS_STAT, v);
    `CHK(v, m_stat)
    for (i = 0; i < 30; i++) begin
      r = $random(seed);
      @(posedge clk);
      irq <= r[9];
      slow <= r[10];
      cond <= r[14:11];
      op = 3'((r & 255) % 6);
      b = r[8] ? DEV : r[23:16];
      run_op(op, b);
    end
    wr_reg(`HIC_OFS_CLEAR, 8'h01);
    @(negedge clk);
    `CHK(clr_n, 1'b0)
    {m_clr, m_sel, m_ctl, m_ind, m_gate, m_data} = {5'h10, 8'h00};
    run_op(3'h2, 8'h00);
    wr_reg(`HIC_OFS_CLEAR, 8'h00);
    m_clr = 1'b0;
    run_op(3'h1, 8'h00);
    run_op(3'h0, DEV);
    run_op(3'h2, 8'h00);
    run_op(3'h0, 8'h3B);
    run_op(3'h1, 8'h00);
    close_out();
  end
endmodule // hic_host_tb
